// ### rtl/sfpi_top.sv
`timescale 1ns/10ps
module sfpi_top
    import sfpi_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic cs_n_i,
    input wire logic sck_i,
    input wire logic bidir_lane0_i,
    output logic bidir_lane0_o,
    output logic bidir_lane0_oe_o,
    input wire logic bidir_lane1_i,
    output logic bidir_lane1_o,
    output logic bidir_lane1_oe_o,
    input wire logic bidir_lane2_i,
    output logic bidir_lane2_o,
    output logic bidir_lane2_oe_o,
    input wire logic bidir_lane3_i,
    output logic bidir_lane3_o,
    output logic bidir_lane3_oe_o,
    input wire logic [7:0] rd_data_i,
    output logic [ADDR_W-1:0] rd_addr_o,
    output logic prog_we_o,
    output logic [ADDR_W-1:0] prog_addr_o,
    output logic [7:0] prog_data_o,
    output logic erase_req_o,
    output logic [1:0] erase_kind_o,
    output logic [ADDR_W-1:0] erase_addr_o,
    output logic [3:0] erase_sector_o,
    output logic wp_lock_o
);

    ////////////////////////////////////////////////////////////////
    // Alignment of an erase base address
    function automatic logic [ADDR_W-1:0] align(
        input logic [ADDR_W-1:0] a,
        input logic [1:0] k
    );
        case (k)
            ER_4K: align = {a[ADDR_W-1:12], 12'h000};
            ER_32K: align = {a[ADDR_W-1:15], 15'h0};
            ER_64K: align = {a[ADDR_W-1:SEC_LSB], 16'h0000};
            default: align = '0;
        endcase
    endfunction : align

    ////////////////////////////////////////////////////////////////
    // Two-stage synchronisers, third stage for edges
    logic [2:0] cs_q, sck_q;
    logic [1:0] d0_q, wp_q, hold_q;
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            cs_q <= 3'h7;
            sck_q <= 3'h0;
            d0_q <= 2'h0;
            wp_q <= 2'h3;
            hold_q <= 2'h3;
        end
        else
        begin
            cs_q <= {cs_q[1:0], cs_n_i};
            sck_q <= {sck_q[1:0], sck_i};
            d0_q <= {d0_q[0], bidir_lane0_i};
            wp_q <= {wp_q[0], bidir_lane2_i};
            hold_q <= {hold_q[0], bidir_lane3_i};
        end
    end

    logic sel, held_q, sck_rise, sck_fall, cs_end;
    logic quad_drv;
    assign sel = ~cs_q[1];
    assign sck_rise = sel & ~held_q & sck_q[1] & ~sck_q[2];
    assign sck_fall = sel & ~held_q & ~sck_q[1] & sck_q[2];
    assign cs_end = cs_q[1] & ~cs_q[2];
    assign quad_drv = bidir_lane2_oe_o;

    ////////////////////////////////////////////////////////////////
    // Pause: entered only while selected and clock low
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            held_q <= 1'b0;
        else if (~sel)
            held_q <= 1'b0;
        else if (quad_drv)
            held_q <= 1'b0; // Pin is our lane 3 here
        else if (~held_q & ~hold_q[1] & ~sck_q[1])
            held_q <= 1'b1;
        else if (hold_q[1])
            held_q <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////
    // Freeze outlasts the lane by the synchroniser depth, else our own data leaks in
    logic [1:0] quad_seen_q;
    logic wp_frozen;
    assign wp_frozen = quad_drv | (|quad_seen_q);
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            quad_seen_q <= 2'h0;
        else
            quad_seen_q <= {quad_seen_q[0], quad_drv};
    end

    // Hardware lock level, frozen while the pin is a lane
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            wp_lock_o <= 1'b0;
        else if (~wp_frozen)
            wp_lock_o <= ~wp_q[1];
    end

    ////////////////////////////////////////////////////////////////
    // Command engine on clock rises, MSB first
    sfpi_state_t state_q;
    sfpi_mode_t mode_q;
    sfpi_kind_t kind_q;
    logic [4:0] cnt_q;
    logic [7:0] sh_q;
    logic [23:0] addr_q;
    logic [1:0] ekind_q;
    logic dummy_q, armed_q;
    logic [7:0] byte_in;
    logic [23:0] addr_in;
    assign byte_in = {sh_q[6:0], d0_q[1]};
    assign addr_in = {addr_q[22:0], d0_q[1]};

    // Self-timed work lives outside; pause never touches it
    always_ff @(posedge clk_i)
    begin
        if (reset_i | ~sel)
        begin
            state_q <= ST_CMD;
            mode_q <= MODE_SINGLE;
            kind_q <= CK_READ;
            cnt_q <= '0;
            sh_q <= '0;
            addr_q <= '0;
            ekind_q <= ER_4K;
            dummy_q <= 1'b0;
            armed_q <= 1'b0;
            prog_we_o <= 1'b0;
        end
        else
        begin
            prog_we_o <= 1'b0;
            if (sck_rise)
            begin
                cnt_q <= cnt_q + 5'h01;
                sh_q <= byte_in;
                case (state_q)
                    ST_CMD:
                    begin
                        if (cnt_q == CMD_LAST)
                        begin
                            cnt_q <= '0;
                            state_q <= ST_ADDR;
                            case (byte_in)
                                OP_READ: kind_q <= CK_READ;
                                OP_FREAD:
                                begin
                                    kind_q <= CK_READ;
                                    dummy_q <= 1'b1;
                                end
                                OP_DREAD:
                                begin
                                    kind_q <= CK_READ;
                                    dummy_q <= 1'b1;
                                    mode_q <= MODE_DUAL;
                                end
                                OP_QREAD:
                                begin
                                    kind_q <= CK_READ;
                                    dummy_q <= 1'b1;
                                    mode_q <= MODE_QUAD;
                                end
                                OP_ER4K:
                                begin
                                    kind_q <= CK_ERASE;
                                    ekind_q <= ER_4K;
                                end
                                OP_ER32K:
                                begin
                                    kind_q <= CK_ERASE;
                                    ekind_q <= ER_32K;
                                end
                                OP_ER64K:
                                begin
                                    kind_q <= CK_ERASE;
                                    ekind_q <= ER_64K;
                                end
                                OP_CHIP_A, OP_CHIP_B:
                                begin
                                    ekind_q <= ER_CHIP;
                                    armed_q <= 1'b1;
                                    state_q <= ST_IGNORE;
                                end
                                OP_PROG: kind_q <= CK_PROG;
                                default: state_q <= ST_IGNORE;
                            endcase
                        end
                    end
                    ST_ADDR:
                    begin
                        addr_q <= addr_in;
                        if (cnt_q == ADDR_LAST)
                        begin
                            cnt_q <= '0;
                            case (kind_q)
                                CK_READ: state_q <= dummy_q ? ST_DUMMY : ST_READ;
                                CK_ERASE:
                                begin
                                    armed_q <= 1'b1;
                                    state_q <= ST_IGNORE;
                                end
                                default: state_q <= ST_PROG;
                            endcase
                        end
                    end
                    ST_DUMMY:
                    begin
                        if (cnt_q == DUMMY_LAST)
                            state_q <= ST_READ;
                    end
                    ST_PROG:
                    begin
                        if (cnt_q == CMD_LAST)
                        begin
                            cnt_q <= '0;
                            prog_we_o <= 1'b1;
                            prog_data_o <= byte_in;
                            // Offset wraps, page stays put
                            prog_addr_o <= addr_q[ADDR_W-1:0];
                            addr_q[PAGE_LSB-1:0] <= addr_q[PAGE_LSB-1:0] + 8'h01;
                        end
                    end
                    default: cnt_q <= '0;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // Erase request at the end of the operation
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            erase_req_o <= 1'b0;
            erase_kind_o <= ER_4K;
            erase_addr_o <= '0;
            erase_sector_o <= '0;
        end
        else
        begin
            erase_req_o <= cs_end & armed_q;
            if (cs_end & armed_q)
            begin
                erase_kind_o <= ekind_q;
                erase_addr_o <= align(addr_q[ADDR_W-1:0], ekind_q);
                erase_sector_o <= addr_q[ADDR_W-1:SEC_LSB];
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // Read path: lanes update on clock falls only
    logic [7:0] cur_byte, out_q;
    logic [2:0] pos_q, step;
    assign cur_byte = (pos_q == 3'h0) ? rd_data_i : out_q;
    always_comb
    begin
        case (mode_q)
            MODE_DUAL: step = W_DUAL;
            MODE_QUAD: step = W_QUAD;
            default: step = W_SINGLE;
        endcase
    end

    // Enables kept apart from the pins so a pause can mask and restore them
    logic [3:0] en_q, en_d;
    always_comb
    begin
        en_d = en_q;
        if (sck_fall & (state_q == ST_READ))
            en_d = {mode_q == MODE_QUAD, mode_q == MODE_QUAD, 1'b1, mode_q != MODE_SINGLE};
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i | ~sel)
        begin
            en_q <= 4'h0;
            bidir_lane0_oe_o <= 1'b0;
            bidir_lane1_oe_o <= 1'b0;
            bidir_lane2_oe_o <= 1'b0;
            bidir_lane3_oe_o <= 1'b0;
        end
        else
        begin
            en_q <= en_d;
            // Pause releases the pins; on resume the held bit is driven again
            bidir_lane0_oe_o <= en_d[0] & ~held_q;
            bidir_lane1_oe_o <= en_d[1] & ~held_q;
            bidir_lane2_oe_o <= en_d[2] & ~held_q;
            bidir_lane3_oe_o <= en_d[3] & ~held_q;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            bidir_lane0_o <= 1'b0;
            bidir_lane1_o <= 1'b0;
            bidir_lane2_o <= 1'b0;
            bidir_lane3_o <= 1'b0;
            out_q <= '0;
            pos_q <= '0;
            rd_addr_o <= '0;
        end
        else if (~sel)
            pos_q <= '0;
        else if ((state_q == ST_ADDR) & sck_rise)
            rd_addr_o <= addr_in[ADDR_W-1:0]; // Dummy clocks must not shift it
        else if (sck_fall & (state_q == ST_READ))
        begin
            case (mode_q)
                MODE_DUAL:
                begin
                    bidir_lane1_o <= cur_byte[7];
                    bidir_lane0_o <= cur_byte[6];
                end
                MODE_QUAD:
                begin
                    bidir_lane3_o <= cur_byte[7];
                    bidir_lane2_o <= cur_byte[6];
                    bidir_lane1_o <= cur_byte[5];
                    bidir_lane0_o <= cur_byte[4];
                end
                default: bidir_lane1_o <= cur_byte[7];
            endcase
            out_q <= cur_byte << step;
            pos_q <= pos_q + step;
            if (pos_q + step == 3'h0)
                rd_addr_o <= rd_addr_o + 20'h00001; // Wraps past top
        end
    end

    ////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    property p_fall_only;
        $changed(bidir_lane1_o) |-> $past(sck_fall);
    endproperty
    a_fall_only: assert property (p_fall_only) else $error("lane1 moved off a fall");
    property p_desel_hiz;
        cs_q[1] |=> !bidir_lane1_oe_o && !bidir_lane0_oe_o;
    endproperty
    a_desel_hiz: assert property (p_desel_hiz) else $error("lane driven while deselected");
    property p_dual;
        bidir_lane0_oe_o |-> mode_q != MODE_SINGLE && bidir_lane1_oe_o;
    endproperty
    a_dual: assert property (p_dual) else $error("lane0 driven outside wide read");
    property p_quad;
        bidir_lane2_oe_o |-> mode_q == MODE_QUAD && bidir_lane3_oe_o;
    endproperty
    a_quad: assert property (p_quad) else $error("quad lanes mismatched");
    property p_wp;
        !wp_frozen && !wp_q[1] |=> wp_lock_o;
    endproperty
    a_wp: assert property (p_wp) else $error("lock missed");
    property p_hold_hiz;
        held_q |=> !bidir_lane1_oe_o;
    endproperty
    a_hold_hiz: assert property (p_hold_hiz) else $error("driven during pause");
    property p_hold_start;
        $rose(held_q) |-> $past(sel && !sck_q[1]);
    endproperty
    a_hold_start: assert property (p_hold_start) else $error("pause began wrongly");
    property p_page;
        prog_we_o |-> addr_q[ADDR_W-1:PAGE_LSB] == prog_addr_o[ADDR_W-1:PAGE_LSB];
    endproperty
    a_page: assert property (p_page) else $error("page moved");
    property p_align;
        erase_req_o && erase_kind_o == ER_4K |-> erase_addr_o[11:0] == 12'h000;
    endproperty
    a_align: assert property (p_align) else $error("erase misaligned");
    property p_erase_end;
        erase_req_o |-> $past(cs_end);
    endproperty
    a_erase_end: assert property (p_erase_end) else $error("erase not at deselect");
    c_quad: cover property (bidir_lane3_oe_o);
    c_erase: cover property (erase_req_o);
    c_hold: cover property ($rose(held_q));
    c_prog: cover property (prog_we_o);

endmodule : sfpi_top

// ### rtl/sfpi_pkg.sv
package sfpi_pkg;
    // Array geometry
    localparam int ADDR_W = 20;
    localparam int PAGE_LSB = 8;
    localparam int SEC_LSB = 16;
    localparam logic [ADDR_W-1:0] TOP_ADDR = 20'hFFFFF;
    // Last bit index of each phase, then bits per clock of each read width
    localparam logic [4:0] CMD_LAST = 5'h07;
    localparam logic [4:0] ADDR_LAST = 5'h17;
    localparam logic [4:0] DUMMY_LAST = 5'h07;
    localparam logic [2:0] W_SINGLE = 3'h1;
    localparam logic [2:0] W_DUAL = 3'h2;
    localparam logic [2:0] W_QUAD = 3'h4;
    // Opcodes
    localparam logic [7:0] OP_READ = 8'h03;
    localparam logic [7:0] OP_FREAD = 8'h0B;
    localparam logic [7:0] OP_DREAD = 8'h3B;
    localparam logic [7:0] OP_QREAD = 8'h6B;
    localparam logic [7:0] OP_ER4K = 8'h20;
    localparam logic [7:0] OP_ER32K = 8'h52;
    localparam logic [7:0] OP_ER64K = 8'hD8;
    localparam logic [7:0] OP_CHIP_A = 8'h60;
    localparam logic [7:0] OP_CHIP_B = 8'hC7;
    localparam logic [7:0] OP_PROG = 8'h02;
    typedef enum logic [2:0] {
        ST_CMD = 3'b000,
        ST_ADDR = 3'b001,
        ST_DUMMY = 3'b010,
        ST_READ = 3'b011,
        ST_PROG = 3'b100,
        ST_IGNORE = 3'b101
    } sfpi_state_t;
    typedef enum logic [1:0] {
        MODE_SINGLE = 2'b00,
        MODE_DUAL = 2'b01,
        MODE_QUAD = 2'b10
    } sfpi_mode_t;
    typedef enum logic [1:0] {
        ER_4K = 2'b00,
        ER_32K = 2'b01,
        ER_64K = 2'b10,
        ER_CHIP = 2'b11
    } sfpi_erase_t;
    typedef enum logic [1:0] {
        CK_READ = 2'b00,
        CK_ERASE = 2'b01,
        CK_PROG = 2'b10
    } sfpi_kind_t;
endpackage : sfpi_pkg

// ### verification/sfpi_host_model.sv
`timescale 1ns/10ps
// Link master in mode 0: the clock is parked low outside frames
module sfpi_host_model (
    input wire logic clk_i,
    input wire logic [3:0] lanes_i,
    output logic cs_n_o,
    output logic sck_o,
    output logic [3:0] drive_o,
    output logic [3:0] drive_oe_o
);
    // Four system clocks per half bit give the 400 ns link period
    localparam int HALF_CLKS = 4;

    // Idle: deselected, clock low, every lane released
    initial
    begin
        cs_n_o = 1'b1;
        sck_o = 1'b0;
        drive_o = 4'hF;
        drive_oe_o = 4'h0;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic half_period();
        repeat (HALF_CLKS) @(negedge clk_i);
    endtask : half_period

    // One link clock; lanes sampled at the instant of the rise
    task automatic tick(output logic [3:0] smp);
        half_period();
        smp = lanes_i;
        sck_o = 1'b1;
        half_period();
        sck_o = 1'b0;
    endtask : tick

    // Select fall opens the frame, clock already low
    task automatic frame_start();
        @(negedge clk_i);
        cs_n_o = 1'b0;
        drive_oe_o[0] = 1'b1;
        half_period();
    endtask : frame_start

    // Select rise closes it; our lanes let go with it
    task automatic frame_end();
        cs_n_o = 1'b1;
        drive_oe_o = 4'h0;
        half_period();
    endtask : frame_end

    // Data set while the clock is low, so it is stable at the rise
    task automatic send_byte(input logic [7:0] b);
        logic [3:0] s;
        for (int i = 7; i >= 0; i--)
        begin
            drive_o[0] = b[i];
            tick(s);
        end
    endtask : send_byte

    task automatic send_addr(input logic [23:0] a);
        send_byte(a[23:16]);
        send_byte(a[15:8]);
        send_byte(a[7:0]);
    endtask : send_addr

    task automatic dummy_clocks(input int n);
        logic [3:0] s;
        repeat (n) tick(s);
    endtask : dummy_clocks

    // Let go of every lane before the device may turn them round
    task automatic release_lanes();
        drive_oe_o = 4'h0;
    endtask : release_lanes

    task automatic recv_byte(input int w, output logic [7:0] b);
        logic [3:0] s;
        b = 8'h00;
        for (int k = 0; k < 8 / w; k++)
        begin
            tick(s);
            if (w == 1)
                b = {b[6:0], s[1]};
            else if (w == 2)
                b = {b[5:0], s[1:0]};
            else
                b = {b[3:0], s};
        end
    endtask : recv_byte

    // Only called between bits, while selected, with the clock low
    task automatic set_pause(input logic on);
        drive_o[3] = 1'b0;
        drive_oe_o[3] = on;
    endtask : set_pause

    task automatic set_wp(input logic on);
        drive_o[2] = 1'b0;
        drive_oe_o[2] = on;
    endtask : set_wp
endmodule : sfpi_host_model

// ### verification/sfpi_top_tb_top.sv
`timescale 1ns/10ps
`define CHECK(what, want, got) begin tests_run++; if ((got) !== (want)) begin mismatches++; \
    $display("unexpected %s expected %h seen %h", what, want, got); end end
module sfpi_top_tb_top;
    import sfpi_pkg::*;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic float_q = 1'b0;
    logic cs_n, sck, prog_we, erase_req, wp_lock;
    logic [3:0] h_d, h_oe, lane, dev_o, dev_oe, erase_sector;
    logic [7:0] rd_data, prog_data, b;
    logic [1:0] erase_kind;
    logic [ADDR_W-1:0] rd_addr, prog_addr, erase_addr;
    int mismatches = 0;
    int tests_run = 0;
    int erase_cnt = 0;
    logic [27:0] prog_q[$];
    logic [7:0] rd_op [4] = '{OP_READ, OP_FREAD, OP_DREAD, OP_QREAD};
    int rd_w [4] = '{1, 1, 2, 4};
    logic [ADDR_W-1:0] rd_adr [4] = '{20'hFFFFF, 20'h12345, 20'h0ABCD, 20'h7FFFE};
    logic [7:0] er_op [5] = '{OP_ER4K, OP_ER32K, OP_ER64K, OP_CHIP_A, OP_CHIP_B};
    logic [ADDR_W-1:0] er_adr [5] = '{20'hFFFFF, 20'h0ABCD, 20'h1FFFF, 20'h00000, 20'h00000};
    logic [ADDR_W-1:0] er_base [5] = '{20'hFF000, 20'h08000, 20'h10000, 20'h00000, 20'h00000};
    sfpi_erase_t er_kind [5] = '{ER_4K, ER_32K, ER_64K, ER_CHIP, ER_CHIP};

    always #25 clk_i = ~clk_i;

    // Array contents: a fixed mix of address bits
    function automatic logic [7:0] pattern(input logic [ADDR_W-1:0] a);
        return a[7:0] ^ {a[19:16], a[11:8]};
    endfunction : pattern

    // Floating lanes 0 and 1 toggle every clock so stale data never matches; lanes 2 and 3 float high
    always @(posedge clk_i) float_q <= ~float_q;
    assign lane[0] = dev_oe[0] ? dev_o[0] : (h_oe[0] ? h_d[0] : float_q);
    assign lane[1] = dev_oe[1] ? dev_o[1] : (h_oe[1] ? h_d[1] : ~float_q);
    assign lane[2] = dev_oe[2] ? dev_o[2] : (h_oe[2] ? h_d[2] : 1'b1);
    assign lane[3] = dev_oe[3] ? dev_o[3] : (h_oe[3] ? h_d[3] : 1'b1);
    assign rd_data = pattern(rd_addr);

    ////////////////////////////////////////////////////////////////////////
    sfpi_top u_sfpi_top (.clk_i(clk_i), .reset_i(reset_i), .cs_n_i(cs_n), .sck_i(sck),
        .bidir_lane0_i(lane[0]), .bidir_lane0_o(dev_o[0]), .bidir_lane0_oe_o(dev_oe[0]),
        .bidir_lane1_i(lane[1]), .bidir_lane1_o(dev_o[1]), .bidir_lane1_oe_o(dev_oe[1]),
        .bidir_lane2_i(lane[2]), .bidir_lane2_o(dev_o[2]), .bidir_lane2_oe_o(dev_oe[2]),
        .bidir_lane3_i(lane[3]), .bidir_lane3_o(dev_o[3]), .bidir_lane3_oe_o(dev_oe[3]),
        .rd_data_i(rd_data), .rd_addr_o(rd_addr), .prog_we_o(prog_we), .prog_addr_o(prog_addr),
        .prog_data_o(prog_data), .erase_req_o(erase_req), .erase_kind_o(erase_kind),
        .erase_addr_o(erase_addr), .erase_sector_o(erase_sector), .wp_lock_o(wp_lock));

    sfpi_host_model u_sfpi_host_model (.clk_i(clk_i), .lanes_i(lane), .cs_n_o(cs_n), .sck_o(sck),
        .drive_o(h_d), .drive_oe_o(h_oe));

    // Single-cycle pulses are caught here, not polled by the tests
    always @(posedge clk_i)
    begin
        if (erase_req === 1'b1)
            erase_cnt++;
        if (prog_we === 1'b1)
            prog_q.push_back({prog_addr, prog_data});
    end

    ////////////////////////////////////////////////////////////////////////
    // Top nibble of the address is junk on purpose
    task automatic t_read(input logic [7:0] op, input int w, input logic [ADDR_W-1:0] a);
        logic [3:0] oe_want;
        oe_want = (w == 1) ? 4'h2 : ((w == 2) ? 4'h3 : 4'hF);
        u_sfpi_host_model.frame_start();
        u_sfpi_host_model.send_byte(op);
        u_sfpi_host_model.send_addr({4'hA, a});
        u_sfpi_host_model.release_lanes();
        if (op != OP_READ)
            u_sfpi_host_model.dummy_clocks(8);
        for (int i = 0; i < 2; i++)
        begin
            u_sfpi_host_model.recv_byte(w, b);
            `CHECK("read byte", pattern(a + ADDR_W'(i)), b)
        end
        `CHECK("lane enables", oe_want, dev_oe)
        u_sfpi_host_model.frame_end();
        repeat (6) @(negedge clk_i);
        `CHECK("lanes released", 4'h0, dev_oe)
        $display("test read %h done", op);
    endtask : t_read

    task automatic t_erase();
        int n;
        for (int i = 0; i < 5; i++)
        begin
            n = erase_cnt;
            u_sfpi_host_model.frame_start();
            u_sfpi_host_model.send_byte(er_op[i]);
            if (i < 3)
                u_sfpi_host_model.send_addr({4'h0, er_adr[i]});
            u_sfpi_host_model.frame_end();
            repeat (8) @(negedge clk_i);
            `CHECK("erase count", n + 1, erase_cnt)
            `CHECK("erase kind", er_kind[i], erase_kind)
            `CHECK("erase base", er_base[i], erase_addr)
            `CHECK("erase sector", er_base[i][19:16], erase_sector)
        end
        // Cut-short address, then an unknown opcode poisoning its frame
        n = erase_cnt;
        u_sfpi_host_model.frame_start();
        u_sfpi_host_model.send_byte(OP_ER4K);
        u_sfpi_host_model.send_byte(8'h12);
        u_sfpi_host_model.send_byte(8'h34);
        u_sfpi_host_model.frame_end();
        u_sfpi_host_model.frame_start();
        u_sfpi_host_model.send_byte(8'h9F);
        u_sfpi_host_model.send_byte(OP_ER4K);
        u_sfpi_host_model.send_addr(24'h012345);
        u_sfpi_host_model.frame_end();
        repeat (8) @(negedge clk_i);
        `CHECK("refused erase count", n, erase_cnt)
        $display("test erase done");
    endtask : t_erase

    // Starts two bytes below a page end, so the third byte wraps
    task automatic t_prog();
        prog_q.delete();
        u_sfpi_host_model.frame_start();
        u_sfpi_host_model.send_byte(OP_PROG);
        u_sfpi_host_model.send_addr(24'h05A3FE);
        for (int i = 0; i < 3; i++)
            u_sfpi_host_model.send_byte(8'hC3 ^ 8'(i));
        u_sfpi_host_model.frame_end();
        repeat (8) @(negedge clk_i);
        `CHECK("program count", 3, prog_q.size())
        for (int i = 0; i < 3 && i < prog_q.size(); i++)
            `CHECK("program write", {12'h5A3, 8'(8'hFE + i), 8'hC3 ^ 8'(i)}, prog_q[i])
        $display("test program done");
    endtask : t_prog

    task automatic t_wp();
        u_sfpi_host_model.set_wp(1'b1);
        repeat (8) @(negedge clk_i);
        `CHECK("lock asserted", 1'b1, wp_lock)
        u_sfpi_host_model.set_wp(1'b0);
        repeat (8) @(negedge clk_i);
        `CHECK("lock with pin floating", 1'b0, wp_lock)
        $display("test write protect done");
    endtask : t_wp

    // Clocks given during the pause must not advance the read
    task automatic t_pause();
        u_sfpi_host_model.frame_start();
        u_sfpi_host_model.send_byte(OP_READ);
        u_sfpi_host_model.send_addr(24'h000100);
        u_sfpi_host_model.release_lanes();
        u_sfpi_host_model.recv_byte(1, b);
        `CHECK("byte before pause", pattern(20'h00100), b)
        u_sfpi_host_model.set_pause(1'b1);
        repeat (8) @(negedge clk_i);
        `CHECK("output in pause", 1'b0, dev_oe[1])
        u_sfpi_host_model.dummy_clocks(5);
        u_sfpi_host_model.set_pause(1'b0);
        repeat (8) @(negedge clk_i);
        u_sfpi_host_model.recv_byte(1, b);
        `CHECK("byte after pause", pattern(20'h00101), b)
        u_sfpi_host_model.frame_end();
        $display("test pause done");
    endtask : t_pause

    ////////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : complete_run

    // Whole run is near 4100 clocks; this allows several times that
    initial
    begin
        #1000000;
        $display("unexpected watchdog expected done seen timeout");
        mismatches++;
        complete_run();
    end

    initial
    begin
        repeat (16) @(posedge clk_i);
        @(negedge clk_i);
        reset_i = 1'b0;
        repeat (4) @(negedge clk_i);
        t_wp();
        for (int i = 0; i < 4; i++)
            t_read(rd_op[i], rd_w[i], rd_adr[i]);
        t_erase();
        t_prog();
        t_pause();
        complete_run();
    end
endmodule : sfpi_top_tb_top
